// *** ccu_params.svh ***
// register offsets, field positions, codes and reset values of the capture/compare unit
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// ==========================================================================
// register byte offsets on the apb bus
`define CCU_OFF_CTRL 8'h00
`define CCU_OFF_TB_LO 8'h04
`define CCU_OFF_TB_HI 8'h08
`define CCU_OFF_VAL_LO 8'h0c
`define CCU_OFF_VAL_HI 8'h10
`define CCU_OFF_TB_CTRL 8'h14
`define CCU_OFF_IRQ_STAT 8'h18
`define CCU_OFF_IRQ_EN 8'h1c
`define CCU_OFF_IRQ_CLR 8'h20

// ==========================================================================
// unit_control_reg fields
`define CCU_CTRL_EN_BIT 7
`define CCU_CTRL_OUT_BIT 5
`define CCU_MODE_MSB 3
`define CCU_MODE_LSB 0

// ==========================================================================
// unit_mode_field codes
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_CMP_TOGGLE 4'h2
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_RISE4 4'h6
`define CCU_MODE_CAP_RISE16 4'h7
`define CCU_MODE_CMP_SET 4'h8
`define CCU_MODE_CMP_CLEAR 4'h9
`define CCU_MODE_CMP_SWINT 4'ha
`define CCU_MODE_CMP_CONV 4'hb

// capture prescaler terminal counts (edges per capture minus one)
`define CCU_PRE_EVERY 4'h0
`define CCU_PRE_FOURTH 4'h3
`define CCU_PRE_SIXTEENTH 4'hf

// ==========================================================================
// time base control fields
`define CCU_TB_ON_BIT 0
`define CCU_TB_CS_LSB 1
`define CCU_TB_ASYNC_BIT 3
`define CCU_TB_CKPS_LSB 4
`define CCU_CS_INSTR 2'h0
`define CCU_CS_SYSOSC 2'h1
`define CCU_CS_EXT 2'h2

// instruction clock is the system clock divided by four
`define CCU_INSTR_DIV_LAST 2'h3

// ==========================================================================
// interrupt status bits
`define CCU_IRQ_UNIT_BIT 0
`define CCU_IRQ_OVF_BIT 1

// reset values
`define CCU_RST_WORD 32'h0000_0000
`define CCU_RST_BYTE 8'h00
`define CCU_RST_CNT 16'h0000

`endif

// *** ccu_pkg.sv ***
// state types shared by the capture/compare unit modules
`default_nettype none

package ccu_pkg;

    // ======================================================================
    // input synchroniser state
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
        logic rise;
        logic fall;
    } ccu_sync_state_t;

    // ======================================================================
    // time base counter state
    typedef struct packed {
        logic [1:0] div;
        logic [2:0] pre;
        logic [15:0] cnt;
        logic adv;
        logic ovf;
    } ccu_tb_state_t;

    // ======================================================================
    // top level state
    typedef struct packed {
        logic en;
        logic [3:0] mode;
        logic tb_on;
        logic [1:0] tb_cs;
        logic tb_async;
        logic [1:0] tb_ckps;
        logic [15:0] val;
        logic [3:0] pre_cnt;
        logic pin_out;
        logic [1:0] stat;
        logic [1:0] ien;
        logic [31:0] prdata;
        logic conv;
        logic wake;
    } ccu_top_state_t;

endpackage

`default_nettype wire

// *** ccu_pin_sync.sv ***
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none

module ccu_pin_sync (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);

    ccu_pkg::ccu_sync_state_t s_q;
    ccu_pkg::ccu_sync_state_t s_d;

    // ======================================================================
    // next state: ff1 only feeds ff2, level follows once ff2 and ff3 agree
    always_comb begin
        s_d = s_q;
        s_d.ff1 = i_pin;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (s_q.ff2 == s_q.ff3 && s_q.ff3 != s_q.level) begin
            s_d.level = s_q.ff3;
            s_d.rise = s_q.ff3;
            s_d.fall = ~s_q.ff3;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;
    assign o_rise = s_q.rise;
    assign o_fall = s_q.fall;

endmodule

`default_nettype wire

// *** ccu_timebase.sv ***
// 16-bit time base counter with clock select and 2-bit prescaler
`timescale 1ns/10ps
`default_nettype none

`include "ccu_params.svh"

module ccu_timebase (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_on,
    input wire logic [1:0] i_clk_src,
    input wire logic [1:0] i_ckps,
    input wire logic i_sleep,
    input wire logic i_ext_rise,
    input wire logic i_wr_lo,
    input wire logic i_wr_hi,
    input wire logic [7:0] i_wdata,
    output logic [15:0] o_count,
    output logic o_adv,
    output logic o_ovf
);

    ccu_pkg::ccu_tb_state_t s_q;
    ccu_pkg::ccu_tb_state_t s_d;

    // last prescaler count before an advance: 1, 2, 4 or 8 source ticks
    function automatic logic [2:0] ccu_pre_last(input logic [1:0] ckps);
        logic [3:0] span;
        span = 4'h1 << ckps;
        return 3'(span - 4'h1);
    endfunction

    // ======================================================================
    // source tick and count advance
    always_comb begin
        logic tick;
        tick = 1'b0;
        s_d = s_q;
        s_d.adv = 1'b0;
        s_d.ovf = 1'b0;
        s_d.div = s_q.div + 2'h1; // instruction clock divider runs always
        unique case (i_clk_src)
            // internal clocks halt in sleep, count is held until wake
            `CCU_CS_INSTR: tick = (s_q.div == `CCU_INSTR_DIV_LAST) && !i_sleep;
            `CCU_CS_SYSOSC: tick = !i_sleep;
            // external source keeps counting through sleep
            `CCU_CS_EXT: tick = i_ext_rise;
            default: tick = 1'b0;
        endcase
        if (i_on && tick) begin
            if (s_q.pre == ccu_pre_last(i_ckps)) begin
                s_d.pre = 3'h0;
                s_d.cnt = s_q.cnt + 16'h0001;
                s_d.adv = 1'b1;
                s_d.ovf = (s_q.cnt == 16'hffff);
            end else begin
                s_d.pre = s_q.pre + 3'h1;
            end
        end
        // software write of either half wins over counting
        if (i_wr_lo) begin
            s_d.cnt[7:0] = i_wdata;
            s_d.adv = 1'b0;
            s_d.ovf = 1'b0;
        end
        if (i_wr_hi) begin
            s_d.cnt[15:8] = i_wdata;
            s_d.adv = 1'b0;
            s_d.ovf = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_count = s_q.cnt;
    assign o_adv = s_q.adv;
    assign o_ovf = s_q.ovf;

endmodule

`default_nettype wire

// *** ccu_top.sv ***
// capture/compare unit with time base, apb registers and interrupt
`timescale 1ns/10ps
`default_nettype none

`include "ccu_params.svh"

module ccu_top (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_unit_pin,
    input wire logic i_ext_clk,
    input wire logic i_sleep,
    output logic o_unit_pin_o,
    output logic o_unit_pin_oe_n,
    output logic o_conv_trig,
    output logic o_irq,
    output logic o_wake
);

    ccu_pkg::ccu_top_state_t s_q;
    ccu_pkg::ccu_top_state_t s_d;

    logic pin_rise;
    logic pin_fall;
    logic ext_rise;
    logic [15:0] tb_count;
    logic tb_adv;
    logic tb_ovf;
    logic wr_en;
    logic wr_tb_lo;
    logic wr_tb_hi;

    // ======================================================================
    // mode and address decoding helpers

    function automatic logic ccu_is_capture(input logic [3:0] mode);
        return mode == `CCU_MODE_CAP_FALL || mode == `CCU_MODE_CAP_RISE ||
            mode == `CCU_MODE_CAP_RISE4 || mode == `CCU_MODE_CAP_RISE16;
    endfunction

    function automatic logic ccu_is_compare(input logic [3:0] mode);
        return mode == `CCU_MODE_CMP_TOGGLE || mode == `CCU_MODE_CMP_SET ||
            mode == `CCU_MODE_CMP_CLEAR || mode == `CCU_MODE_CMP_SWINT ||
            mode == `CCU_MODE_CMP_CONV;
    endfunction

    // edges per capture, less one, for each capture setting
    function automatic logic [3:0] ccu_pre_last(input logic [3:0] mode);
        logic [3:0] last;
        last = `CCU_PRE_EVERY;
        if (mode == `CCU_MODE_CAP_RISE4) begin
            last = `CCU_PRE_FOURTH;
        end else if (mode == `CCU_MODE_CAP_RISE16) begin
            last = `CCU_PRE_SIXTEENTH;
        end
        return last;
    endfunction

    function automatic logic ccu_mapped(input logic [7:0] addr);
        return addr == `CCU_OFF_CTRL || addr == `CCU_OFF_TB_LO ||
            addr == `CCU_OFF_TB_HI || addr == `CCU_OFF_VAL_LO ||
            addr == `CCU_OFF_VAL_HI || addr == `CCU_OFF_TB_CTRL ||
            addr == `CCU_OFF_IRQ_STAT || addr == `CCU_OFF_IRQ_EN ||
            addr == `CCU_OFF_IRQ_CLR;
    endfunction

    // ======================================================================
    // pin and external clock synchronisers

    ccu_pin_sync u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin(i_unit_pin),
        .o_level(),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // external counter clock is sampled, so it must run well below 25 mhz / 4
    ccu_pin_sync u_ext_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin(i_ext_clk),
        .o_level(),
        .o_rise(ext_rise),
        .o_fall()
    );

    // ======================================================================
    // time base

    assign wr_en = i_psel && i_penable && i_pwrite;
    assign wr_tb_lo = wr_en && (i_paddr == `CCU_OFF_TB_LO);
    assign wr_tb_hi = wr_en && (i_paddr == `CCU_OFF_TB_HI);

    ccu_timebase u_timebase (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_on(s_q.tb_on),
        .i_clk_src(s_q.tb_cs),
        .i_ckps(s_q.tb_ckps),
        .i_sleep(i_sleep),
        .i_ext_rise(ext_rise),
        .i_wr_lo(wr_tb_lo),
        .i_wr_hi(wr_tb_hi),
        .i_wdata(i_pwdata[7:0]),
        .o_count(tb_count),
        .o_adv(tb_adv),
        .o_ovf(tb_ovf)
    );

    // ======================================================================
    // capture, compare, interrupt and register logic
    always_comb begin
        logic capturing;
        logic comparing;
        logic cap_ok;
        logic edge_seen;
        logic cap_evt;
        logic match;
        logic [1:0] set_bits;
        logic [1:0] clr_bits;
        logic [31:0] rd;
        capturing = 1'b0;
        comparing = 1'b0;
        cap_ok = 1'b0;
        edge_seen = 1'b0;
        cap_evt = 1'b0;
        match = 1'b0;
        set_bits = 2'h0;
        clr_bits = 2'h0;
        rd = `CCU_RST_WORD;
        s_d = s_q;
        s_d.conv = 1'b0;
        s_d.wake = 1'b0;

        capturing = s_q.en && ccu_is_capture(s_q.mode);
        comparing = s_q.en && ccu_is_compare(s_q.mode);

        // capture needs a synchronous time base on the instruction or external
        // clock; an internal clock is dead in sleep, so is capture then
        cap_ok = s_q.tb_on && !s_q.tb_async && (s_q.tb_cs != `CCU_CS_SYSOSC) &&
            (!i_sleep || s_q.tb_cs == `CCU_CS_EXT);

        // edge counting through the capture prescaler
        edge_seen = (s_q.mode == `CCU_MODE_CAP_FALL) ? pin_fall : pin_rise;
        if (!capturing) begin
            s_d.pre_cnt = 4'h0;
        end else if (edge_seen && cap_ok) begin
            // >= so a smaller new setting fires on the next edge: kept count
            if (s_q.pre_cnt >= ccu_pre_last(s_q.mode)) begin
                s_d.pre_cnt = 4'h0;
                cap_evt = 1'b1;
            end else begin
                s_d.pre_cnt = s_q.pre_cnt + 4'h1;
            end
        end
        if (cap_evt) begin
            s_d.val = tb_count;
        end

        // one look per advance, so a stopped counter cannot rematch
        match = comparing && tb_adv && (tb_count == s_q.val);
        if (match) begin
            unique case (s_q.mode)
                `CCU_MODE_CMP_TOGGLE: s_d.pin_out = ~s_q.pin_out;
                `CCU_MODE_CMP_SET: s_d.pin_out = 1'b1;
                `CCU_MODE_CMP_CLEAR: s_d.pin_out = 1'b0;
                `CCU_MODE_CMP_CONV: s_d.conv = 1'b1;
                default: s_d.pin_out = s_q.pin_out;
            endcase
        end

        // wake on overflow only from the asynchronous external counter
        s_d.wake = tb_ovf && s_q.tb_async && (s_q.tb_cs == `CCU_CS_EXT) && i_sleep;

        // interrupt status events
        set_bits[`CCU_IRQ_UNIT_BIT] = cap_evt || match;
        set_bits[`CCU_IRQ_OVF_BIT] = tb_ovf;

        // register writes, taken in the access phase
        if (wr_en) begin
            unique case (i_paddr)
                `CCU_OFF_CTRL: begin
                    // a zero write disables and so clears the prescaler
                    s_d.en = i_pwdata[`CCU_CTRL_EN_BIT];
                    s_d.mode = i_pwdata[`CCU_MODE_MSB:`CCU_MODE_LSB];
                end
                `CCU_OFF_VAL_LO: s_d.val[7:0] = i_pwdata[7:0];
                `CCU_OFF_VAL_HI: s_d.val[15:8] = i_pwdata[7:0];
                `CCU_OFF_TB_CTRL: begin
                    s_d.tb_on = i_pwdata[`CCU_TB_ON_BIT];
                    s_d.tb_cs = i_pwdata[`CCU_TB_CS_LSB +: 2];
                    s_d.tb_async = i_pwdata[`CCU_TB_ASYNC_BIT];
                    s_d.tb_ckps = i_pwdata[`CCU_TB_CKPS_LSB +: 2];
                end
                `CCU_OFF_IRQ_EN: s_d.ien = i_pwdata[1:0];
                `CCU_OFF_IRQ_CLR: clr_bits = i_pwdata[1:0];
                default: s_d.ien = s_q.ien;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s_d.stat = (s_q.stat & ~clr_bits) | set_bits;

        // read data is prepared in the setup phase so it leaves a flip-flop
        unique case (i_paddr)
            `CCU_OFF_CTRL: begin
                rd[`CCU_CTRL_EN_BIT] = s_q.en;
                rd[`CCU_CTRL_OUT_BIT] = s_q.pin_out;
                rd[`CCU_MODE_MSB:`CCU_MODE_LSB] = s_q.mode;
            end
            `CCU_OFF_TB_LO: rd[7:0] = tb_count[7:0];
            `CCU_OFF_TB_HI: rd[7:0] = tb_count[15:8];
            `CCU_OFF_VAL_LO: rd[7:0] = s_q.val[7:0];
            `CCU_OFF_VAL_HI: rd[7:0] = s_q.val[15:8];
            `CCU_OFF_TB_CTRL: begin
                rd[`CCU_TB_ON_BIT] = s_q.tb_on;
                rd[`CCU_TB_CS_LSB +: 2] = s_q.tb_cs;
                rd[`CCU_TB_ASYNC_BIT] = s_q.tb_async;
                rd[`CCU_TB_CKPS_LSB +: 2] = s_q.tb_ckps;
            end
            `CCU_OFF_IRQ_STAT: rd[1:0] = s_q.stat;
            `CCU_OFF_IRQ_EN: rd[1:0] = s_q.ien;
            default: rd = `CCU_RST_WORD;
        endcase
        if (i_psel && !i_penable && !i_pwrite) begin
            s_d.prdata = rd;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // outputs: bus answers at once, zero wait states
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !ccu_mapped(i_paddr);
    assign o_prdata = s_q.prdata;

    // pin driven only while a compare mode is active
    assign o_unit_pin_o = s_q.pin_out;
    assign o_unit_pin_oe_n = ~(s_q.en && ccu_is_compare(s_q.mode));
    assign o_conv_trig = s_q.conv;
    assign o_wake = s_q.wake;
    assign o_irq = |(s_q.stat & s_q.ien);

endmodule

`default_nettype wire

// *** ccu_pin_model.sv ***
// far-side model of the unit pin and the external count clock
`timescale 1ns/10ps
`default_nettype none

module ccu_pin_model (
    input wire logic i_lvl,
    input wire logic i_run,
    input wire logic i_pin_o,
    input wire logic i_pin_oe_n,
    output logic o_pin,
    output logic o_ext_clk
);
    logic drv;

    // ======================================================================
    // pin wire: the unit wins while it drives, else a slow far-side driver
    assign #3 drv = i_lvl;
    assign o_pin = i_pin_oe_n ? drv : i_pin_o;

    // ======================================================================
    // external count clock, unrelated phase, stands low outside bursts
    initial begin
        o_ext_clk = 1'b0;
        forever begin
            #173;
            o_ext_clk = i_run ? ~o_ext_clk : 1'b0;
        end
    end
endmodule

`default_nettype wire

// *** ccu_top_asserts.sv ***
// concurrent checks on the capture/compare unit ports
`timescale 1ns/10ps
`default_nettype none

`include "ccu_params.svh"

module ccu_top_asserts (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_sleep,
    input wire logic o_unit_pin_o,
    input wire logic o_unit_pin_oe_n,
    input wire logic o_conv_trig,
    input wire logic o_irq,
    input wire logic o_wake
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // ======================================================================
    // bus phases
    sequence s_access;
        i_psel && i_penable;
    endsequence
    sequence s_mask_off;
        s_access ##0 (i_pwrite && i_paddr == `CCU_OFF_IRQ_EN && i_pwdata[1:0] == 2'h0);
    endsequence

    // ======================================================================
    // bus answers and irq masking
    a_ready_zero_wait: assert property (s_access |-> o_pready)
        else $error("pready low in access phase");
    a_unmapped_refused: assert property (s_access ##0 i_paddr > 8'h20 |->
        o_pslverr && (i_pwrite || o_prdata == 32'h0))
        else $error("unmapped access not refused");
    a_irq_mask_off: assert property (s_mask_off |=> !o_irq)
        else $error("irq high with enables cleared");

    // ======================================================================
    // match and wake pulses, undriven pin hold
    a_conv_one_cycle: assert property (o_conv_trig |=> !o_conv_trig)
        else $error("conversion trigger longer than one cycle");
    a_conv_pin_driven: assert property (o_conv_trig |-> !o_unit_pin_oe_n)
        else $error("conversion trigger outside compare mode");
    a_wake_one_cycle: assert property (o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    a_wake_needs_sleep: assert property (o_wake |-> $past(i_sleep))
        else $error("wake while awake");
    a_pin_hold_off: assert property (o_unit_pin_oe_n |=> $stable(o_unit_pin_o))
        else $error("pin moved while not driven");
endmodule

bind ccu_top ccu_top_asserts i_ccu_top_asserts (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_sleep(i_sleep), .o_unit_pin_o(o_unit_pin_o), .o_unit_pin_oe_n(o_unit_pin_oe_n),
    .o_conv_trig(o_conv_trig), .o_irq(o_irq), .o_wake(o_wake));

`default_nettype wire

// *** tb.sv ***
// self-checking testbench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none

`include "ccu_params.svh"

module tb;
    logic clk, nrst, psel, pen, pwr, slp, lvl, run, pin_w, ext;
    logic rdy, err, e, po, poe_n, conv, irq, wake;
    logic [7:0] addr;
    logic [31:0] wd, rd, prd, v;
    int errors = 0;
    int check_count = 0;

    // ======================================================================
    // design and far-side model
    ccu_top i_ccu_top (.i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .i_unit_pin(pin_w), .i_ext_clk(ext), .i_sleep(slp),
        .o_unit_pin_o(po), .o_unit_pin_oe_n(poe_n), .o_conv_trig(conv), .o_irq(irq),
        .o_wake(wake));
    ccu_pin_model i_ccu_pin_model (.i_lvl(lvl), .i_run(run), .i_pin_o(po),
        .i_pin_oe_n(poe_n), .o_pin(pin_w), .o_ext_clk(ext));

    // ======================================================================
    // clock, 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ======================================================================
    // shared tasks
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; waits on pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 64);
        rd = prd;
        e = err;
        chk("pready", 32'h1, rdy);
        if (rdy !== 1'b1) end_sim();
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // poll irq for at most lim cycles, then judge it; the first look waits
    // past the edge so a flag set or cleared on that edge has settled
    task automatic wait_irq(input int lim, input logic exp, input string nm);
        int n;
        n = 0;
        #1;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(nm, exp, irq);
    endtask

    task automatic pulses(input int k);
        repeat (k) begin
            @(posedge clk);
            lvl <= 1'b1;
            repeat (8) @(posedge clk);
            lvl <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask

    // safe mode change: irq masked, unit off first, flag cleared after
    task automatic cap(input logic [3:0] md, input int k, input logic exp, input string nm);
        apb(1'b1, `CCU_OFF_IRQ_EN, 32'h0);
        apb(1'b1, `CCU_OFF_CTRL, 32'h0);
        apb(1'b1, `CCU_OFF_CTRL, {24'h0, 4'h8, md});
        apb(1'b1, `CCU_OFF_IRQ_CLR, 32'h3);
        apb(1'b1, `CCU_OFF_IRQ_EN, 32'h1);
        pulses(k);
        wait_irq(20, exp, nm);
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        chk("oe_n", 32'h1, poe_n);
        chk("irq", 32'h0, irq);
        apb(1'b0, `CCU_OFF_CTRL, 32'h0);
        chk("ctrl", `CCU_RST_WORD, rd);
        apb(1'b1, `CCU_OFF_IRQ_STAT, 32'h3);
        apb(1'b0, `CCU_OFF_IRQ_STAT, 32'h0);
        chk("stat", `CCU_RST_WORD, rd);
        apb(1'b0, 8'h24, 32'h0);
        chk("slverr", 32'h1, e);
        chk("unmapped", 32'h0, rd);
    endtask

    // every compare action; count holds 8 cycles on each value
    task automatic t_compare();
        logic [3:0] m [5] = '{`CCU_MODE_CMP_SET, `CCU_MODE_CMP_CLEAR, `CCU_MODE_CMP_TOGGLE,
            `CCU_MODE_CMP_SWINT, `CCU_MODE_CMP_CONV};
        logic [4:0] pe = 5'h1d;
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'h33);
        apb(1'b1, `CCU_OFF_VAL_LO, 32'h40);
        apb(1'b1, `CCU_OFF_IRQ_EN, 32'h1);
        foreach (m[i]) begin
            apb(1'b1, `CCU_OFF_CTRL, 32'h0);
            apb(1'b1, `CCU_OFF_TB_HI, 32'h0);
            apb(1'b1, `CCU_OFF_TB_LO, 32'h0);
            apb(1'b1, `CCU_OFF_IRQ_CLR, 32'h3);
            apb(1'b1, `CCU_OFF_CTRL, {24'h0, 4'h8, m[i]});
            wait_irq(700, 1'b1, "cmp irq");
            chk("cmp pin", pe[i], po);
            chk("cmp oe_n", 32'h0, poe_n);
            chk("cmp conv", m[i] == `CCU_MODE_CMP_CONV, conv);
            apb(1'b1, `CCU_OFF_IRQ_CLR, 32'h1);
            wait_irq(40, 1'b0, "one match");
        end
    endtask

    task automatic t_capture();
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'h1);
        cap(`CCU_MODE_CAP_RISE, 1, 1'b1, "cap rise");
        cap(`CCU_MODE_CAP_FALL, 1, 1'b1, "cap fall");
        cap(`CCU_MODE_CAP_RISE4, 3, 1'b0, "cap 4 early");
        pulses(1);
        wait_irq(20, 1'b1, "cap 4th");
        cap(`CCU_MODE_CAP_RISE16, 15, 1'b0, "cap 16 early");
        cap(`CCU_MODE_CAP_RISE4, 3, 1'b0, "pre cleared");
        apb(1'b1, `CCU_OFF_CTRL, 32'h87);
        apb(1'b1, `CCU_OFF_IRQ_CLR, 32'h3);
        pulses(12);
        wait_irq(20, 1'b0, "pre kept early");
        pulses(1);
        wait_irq(20, 1'b1, "pre kept");
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'h9);
        cap(`CCU_MODE_CAP_RISE, 1, 1'b0, "async cap");
    endtask

    task automatic t_sleep();
        int n;
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'h1);
        slp <= 1'b1;
        apb(1'b0, `CCU_OFF_TB_LO, 32'h0);
        v = rd;
        repeat (40) @(posedge clk);
        apb(1'b0, `CCU_OFF_TB_LO, 32'h0);
        chk("sleep hold", v, rd);
        slp <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, `CCU_OFF_TB_LO, 32'h0);
        chk("resume", 32'h1, rd != v);
        run <= 1'b1;
        slp <= 1'b1;
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'h5);
        cap(`CCU_MODE_CAP_RISE, 1, 1'b1, "sleep cap");
        apb(1'b1, `CCU_OFF_TB_CTRL, 32'hd);
        apb(1'b1, `CCU_OFF_TB_HI, 32'hff);
        apb(1'b1, `CCU_OFF_TB_LO, 32'hfe);
        n = 0;
        while (wake !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wake", 32'h1, wake);
        apb(1'b0, `CCU_OFF_IRQ_STAT, 32'h0);
        chk("ovf flag", 32'h1, rd[1]);
    endtask

    // ======================================================================
    // main sequence and hang guard
    initial begin
        {nrst, psel, pen, pwr, slp, lvl, run} = 7'h0;
        addr = 8'h0;
        wd = 32'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_compare();
        t_capture();
        t_sleep();
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
